//--- logic/hcr_defines.vh
`ifndef HCR_DEFINES_VH
`define HCR_DEFINES_VH

// ----------------------------------------
// register offsets on the hub serial line
// ----------------------------------------
`define HCR_OFS_IDENT 4'h2
`define HCR_OFS_EXP 4'h4
`define HCR_OFS_CHA 4'h6
`define HCR_OFS_CHB 4'h8

// ----------------------------------------
// reset values
// ----------------------------------------
`define HCR_RST_IDENT 16'h04C0
`define HCR_RST_EXP 16'h0000
`define HCR_RST_CHA 16'h0000
`define HCR_RST_CHB 16'h0000

// ----------------------------------------
// field positions and fixed masks
// ----------------------------------------
`define HCR_ID_MSB 2
`define HCR_HUB_MASK_LSB 5
`define HCR_CHAN_MASK_LSB 10
`define HCR_HUB_MASK 3'h6
`define HCR_CHAN_MASK 3'h1
`define HCR_EXP_CHA_BIT 9
`define HCR_EXP_CHB_BIT 10
`define HCR_DRIVE_MSB 6

// ----------------------------------------
// writable bits per register
// ----------------------------------------
`define HCR_WMASK_IDENT 16'h0007
`define HCR_WMASK_EXP 16'h067F
`define HCR_WMASK_CHA 16'h007F
`define HCR_WMASK_CHB 16'h007F

// ----------------------------------------
// serial frame layout and timing counts
// ----------------------------------------
`define HCR_CMD_WRITE 2'h0
`define HCR_CMD_READ 2'h1
`define HCR_CMD_DEVRST 2'h2
`define HCR_CMD_SETID 2'h3
`define HCR_HEAD_LAST 5'h08
`define HCR_DATA_LAST 5'h0F
`define HCR_IDLE_LIMIT 12'hFFF

`endif

//--- logic/hcr_sync.v
`timescale 1ns/100ps

module hcr_sync #(
	parameter WIDTH = 2
) (
	// clock, reset, enable
	input wire SYS_CLK,
	input wire RST_N,
	input wire CE,
	// pins in, synchronised out
	input wire [WIDTH-1:0] D,
	output wire [WIDTH-1:0] Q
);

	reg [WIDTH-1:0] meta;
	reg [WIDTH-1:0] stable;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			always @(posedge SYS_CLK or negedge RST_N)
			begin
				if (!RST_N)
				begin
					meta[i] <= 1'b0;
					stable[i] <= 1'b0;
				end
				else if (CE)
				begin
					meta[i] <= D[i];
					stable[i] <= meta[i];
				end
			end
		end
	endgenerate

	assign Q = stable;

endmodule

//--- logic/hcr_match.v
`timescale 1ns/100ps
`include "hcr_defines.vh"

module hcr_match (
	// clock, reset, enable
	input wire SYS_CLK,
	input wire RST_N,
	input wire CE,
	// packet from the expansion channel
	input wire PKT_VALID,
	input wire [2:0] PKT_ID,
	// hub configuration
	input wire [2:0] DEV_ID,
	input wire CHA_ON,
	input wire CHB_ON,
	// decision, registered
	output reg HIT,
	output reg CHA_HIT,
	output reg CHB_HIT
);

	// mask zero bits suppress identity bits
	function [2:0] apply_mask;
		input [2:0] ident;
		input [2:0] mask;
		begin
			apply_mask = ident & mask;
		end
	endfunction

	wire hub_eq;
	wire chan_sel;

	assign hub_eq = apply_mask(PKT_ID, `HCR_HUB_MASK) == apply_mask(DEV_ID, `HCR_HUB_MASK);
	assign chan_sel = |apply_mask(PKT_ID, `HCR_CHAN_MASK);

	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			HIT <= 1'b0;
			CHA_HIT <= 1'b0;
			CHB_HIT <= 1'b0;
		end
		else if (CE)
		begin
			HIT <= PKT_VALID & hub_eq;
			// a switched-off channel never sees traffic
			CHA_HIT <= PKT_VALID & hub_eq & ~chan_sel & CHA_ON;
			CHB_HIT <= PKT_VALID & hub_eq & chan_sel & CHB_ON;
		end
	end

endmodule

//--- logic/hcr_top.v
`timescale 1ns/100ps
`include "hcr_defines.vh"

module hcr_top (
	// clock, reset, enable
	input wire SYS_CLK,
	input wire RST_N,
	input wire CE,
	// hub serial line
	input wire SIO_SCK,
	input wire SIO_IN,
	output reg SIO_OUT,
	output reg SIO_OE,
	// expansion row packet identity
	input wire ROW_VALID,
	input wire [2:0] ROW_ID,
	// expansion column packet identity
	input wire COL_VALID,
	input wire [2:0] COL_ID,
	// addressing decisions
	output wire ROW_HIT,
	output wire ROW_CHA_HIT,
	output wire ROW_CHB_HIT,
	output wire COL_HIT,
	output wire COL_CHA_HIT,
	output wire COL_CHB_HIT,
	// configuration outputs
	output reg [2:0] HUB_ID,
	output reg [6:0] EXP_DRIVE,
	output reg CHA_ON,
	output reg [6:0] CHA_DRIVE,
	output reg CHB_ON,
	output reg [6:0] CHB_DRIVE
);

	// ----------------------------------------
	// states and masked reset values
	// ----------------------------------------
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_HEAD = 5'h02;
	localparam [4:0] ST_WDATA = 5'h04;
	localparam [4:0] ST_RDATA = 5'h08;
	localparam [4:0] ST_SKIP = 5'h10;
	localparam [15:0] RST_IDENT = `HCR_RST_IDENT & `HCR_WMASK_IDENT;
	localparam [15:0] RST_EXP = `HCR_RST_EXP & `HCR_WMASK_EXP;
	localparam [15:0] RST_CHA = `HCR_RST_CHA & `HCR_WMASK_CHA;
	localparam [15:0] RST_CHB = `HCR_RST_CHB & `HCR_WMASK_CHB;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg [4:0] state;
	reg [4:0] cnt;
	reg [7:0] head;
	reg [15:0] shift;
	reg [1:0] cur_cmd;
	reg cur_hit;
	reg [3:0] cur_addr;
	reg sck_prev;
	reg [11:0] idle_cnt;
	wire sck_s;
	wire sio_s;
	wire sck_rise;
	wire sck_fall;
	wire [8:0] head_next;
	wire [15:0] word_next;
	wire [15:0] rd_word;
	wire head_hit;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function is_mapped;
		input [3:0] addr;
		begin
			case (addr)
				`HCR_OFS_IDENT: is_mapped = 1'b1;
				`HCR_OFS_EXP: is_mapped = 1'b1;
				`HCR_OFS_CHA: is_mapped = 1'b1;
				`HCR_OFS_CHB: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// reserved bits are built as constant zero
	function [15:0] read_word;
		input [3:0] addr;
		input [2:0] id;
		input [6:0] exp_drv;
		input cha;
		input chb;
		input [6:0] cha_drv;
		input [6:0] chb_drv;
		begin
			read_word = 16'h0000;
			if (is_mapped(addr))
			begin
				case (addr)
					`HCR_OFS_IDENT:
					begin
						read_word[`HCR_ID_MSB:0] = id;
						read_word[`HCR_HUB_MASK_LSB+2:`HCR_HUB_MASK_LSB] = `HCR_HUB_MASK;
						read_word[`HCR_CHAN_MASK_LSB+2:`HCR_CHAN_MASK_LSB] = `HCR_CHAN_MASK;
					end
					`HCR_OFS_EXP:
					begin
						read_word[`HCR_DRIVE_MSB:0] = exp_drv;
						read_word[`HCR_EXP_CHA_BIT] = cha;
						read_word[`HCR_EXP_CHB_BIT] = chb;
					end
					`HCR_OFS_CHA: read_word[`HCR_DRIVE_MSB:0] = cha_drv;
					`HCR_OFS_CHB: read_word[`HCR_DRIVE_MSB:0] = chb_drv;
					default: read_word = 16'h0000;
				endcase
			end
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	hcr_sync #(
		.WIDTH(2)
	) u_sync (
		.SYS_CLK(SYS_CLK),
		.RST_N(RST_N),
		.CE(CE),
		.D({SIO_SCK, SIO_IN}),
		.Q({sck_s, sio_s})
	);

	assign sck_rise = sck_s & ~sck_prev;
	assign sck_fall = ~sck_s & sck_prev;
	assign head_next = {head, sio_s};
	assign word_next = {shift[14:0], sio_s};
	assign head_hit = head_next[6:4] == HUB_ID;
	assign rd_word = read_word(head_next[3:0], HUB_ID, EXP_DRIVE, CHA_ON, CHB_ON, CHA_DRIVE, CHB_DRIVE);

	// ----------------------------------------
	// serial frame engine and registers
	// ----------------------------------------
	// frame: start 1, cmd 2, id 3, addr 4, then 16 data bits msb first (none after a device reset)
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state <= ST_IDLE;
			cnt <= 5'h00;
			head <= 8'h00;
			shift <= 16'h0000;
			cur_cmd <= `HCR_CMD_WRITE;
			cur_hit <= 1'b0;
			cur_addr <= 4'h0;
			sck_prev <= 1'b0;
			idle_cnt <= 12'h000;
			SIO_OUT <= 1'b0;
			SIO_OE <= 1'b0;
			HUB_ID <= RST_IDENT[`HCR_ID_MSB:0];
			EXP_DRIVE <= RST_EXP[`HCR_DRIVE_MSB:0];
			CHA_ON <= RST_EXP[`HCR_EXP_CHA_BIT];
			CHB_ON <= RST_EXP[`HCR_EXP_CHB_BIT];
			CHA_DRIVE <= RST_CHA[`HCR_DRIVE_MSB:0];
			CHB_DRIVE <= RST_CHB[`HCR_DRIVE_MSB:0];
		end
		else if (CE)
		begin
			sck_prev <= sck_s;
			// a stalled host must not leave the shared line driven
			if (state == ST_IDLE || sck_rise || sck_fall)
				idle_cnt <= 12'h000;
			else
				idle_cnt <= idle_cnt + 12'h001;
			if (state != ST_IDLE && idle_cnt == `HCR_IDLE_LIMIT)
			begin
				state <= ST_IDLE;
				SIO_OE <= 1'b0;
			end
			else
			begin
				case (state)
					ST_IDLE:
					begin
						if (sck_rise && sio_s)
						begin
							state <= ST_HEAD;
							cnt <= 5'h00;
						end
					end
					ST_HEAD:
					begin
						if (sck_rise)
						begin
							head <= head_next[7:0];
							if (cnt == `HCR_HEAD_LAST)
							begin
								cnt <= 5'h00;
								cur_cmd <= head_next[8:7];
								cur_hit <= head_hit;
								cur_addr <= head_next[3:0];
								case (head_next[8:7])
									`HCR_CMD_READ:
									begin
										shift <= rd_word;
										state <= head_hit ? ST_RDATA : ST_SKIP;
									end
									`HCR_CMD_DEVRST:
									begin
										// broadcast: every hub returns to defaults
										HUB_ID <= RST_IDENT[`HCR_ID_MSB:0];
										EXP_DRIVE <= RST_EXP[`HCR_DRIVE_MSB:0];
										CHA_ON <= RST_EXP[`HCR_EXP_CHA_BIT];
										CHB_ON <= RST_EXP[`HCR_EXP_CHB_BIT];
										CHA_DRIVE <= RST_CHA[`HCR_DRIVE_MSB:0];
										CHB_DRIVE <= RST_CHB[`HCR_DRIVE_MSB:0];
										state <= ST_IDLE;
									end
									default: state <= ST_WDATA;
								endcase
							end
							else
								cnt <= cnt + 5'h01;
						end
					end
					ST_WDATA:
					begin
						if (sck_rise)
						begin
							shift <= word_next;
							if (cnt == `HCR_DATA_LAST)
							begin
								state <= ST_IDLE;
								if (cur_cmd == `HCR_CMD_SETID)
									HUB_ID <= word_next[`HCR_ID_MSB:0];
								else if (cur_hit && is_mapped(cur_addr))
								begin
									// only writable bits are stored
									case (cur_addr)
										`HCR_OFS_IDENT: HUB_ID <= word_next[`HCR_ID_MSB:0];
										`HCR_OFS_EXP:
										begin
											EXP_DRIVE <= word_next[`HCR_DRIVE_MSB:0];
											CHA_ON <= word_next[`HCR_EXP_CHA_BIT];
											CHB_ON <= word_next[`HCR_EXP_CHB_BIT];
										end
										`HCR_OFS_CHA: CHA_DRIVE <= word_next[`HCR_DRIVE_MSB:0];
										`HCR_OFS_CHB: CHB_DRIVE <= word_next[`HCR_DRIVE_MSB:0];
										default: HUB_ID <= HUB_ID;
									endcase
								end
							end
							else
								cnt <= cnt + 5'h01;
						end
					end
					ST_RDATA:
					begin
						// drive on falling edges so the host samples on rising ones
						if (sck_fall)
						begin
							SIO_OE <= 1'b1;
							SIO_OUT <= shift[15];
							shift <= {shift[14:0], 1'b0};
						end
						if (sck_rise)
						begin
							if (cnt == `HCR_DATA_LAST)
							begin
								state <= ST_IDLE;
								SIO_OE <= 1'b0;
								SIO_OUT <= 1'b0;
							end
							else
								cnt <= cnt + 5'h01;
						end
					end
					ST_SKIP:
					begin
						// another hub answers; stay off the line
						if (sck_rise)
						begin
							if (cnt == `HCR_DATA_LAST)
								state <= ST_IDLE;
							else
								cnt <= cnt + 5'h01;
						end
					end
					default:
					begin
						state <= ST_IDLE;
						SIO_OE <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// expansion packet identity match
	// ----------------------------------------
	hcr_match u_row_match (
		.SYS_CLK(SYS_CLK),
		.RST_N(RST_N),
		.CE(CE),
		.PKT_VALID(ROW_VALID),
		.PKT_ID(ROW_ID),
		.DEV_ID(HUB_ID),
		.CHA_ON(CHA_ON),
		.CHB_ON(CHB_ON),
		.HIT(ROW_HIT),
		.CHA_HIT(ROW_CHA_HIT),
		.CHB_HIT(ROW_CHB_HIT)
	);

	hcr_match u_col_match (
		.SYS_CLK(SYS_CLK),
		.RST_N(RST_N),
		.CE(CE),
		.PKT_VALID(COL_VALID),
		.PKT_ID(COL_ID),
		.DEV_ID(HUB_ID),
		.CHA_ON(CHA_ON),
		.CHB_ON(CHB_ON),
		.HIT(COL_HIT),
		.CHA_HIT(COL_CHA_HIT),
		.CHB_HIT(COL_CHB_HIT)
	);

endmodule

//--- verif/hcr_top_assertions.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checker for the register bank
// ----------------------------------------
module hcr_top_assertions (
	// clock, reset, enable
	input wire SYS_CLK,
	input wire RST_N,
	input wire CE,
	// serial line
	input wire SIO_SCK,
	input wire SIO_OE,
	// packets
	input wire ROW_VALID,
	input wire [2:0] ROW_ID,
	input wire COL_VALID,
	input wire [2:0] COL_ID,
	// decisions
	input wire ROW_HIT,
	input wire ROW_CHA_HIT,
	input wire ROW_CHB_HIT,
	input wire COL_HIT,
	input wire COL_CHA_HIT,
	input wire COL_CHB_HIT,
	// configuration
	input wire [2:0] HUB_ID,
	input wire [6:0] EXP_DRIVE,
	input wire CHA_ON,
	input wire [6:0] CHA_DRIVE,
	input wire CHB_ON,
	input wire [6:0] CHB_DRIVE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_row;
		CE && ROW_VALID;
	endsequence
	sequence s_col;
		CE && COL_VALID;
	endsequence
	property p_row_hit;
		s_row |=> ROW_HIT == ((($past(ROW_ID) ^ $past(HUB_ID)) & 3'h6) == 3'h0);
	endproperty
	a_row_hit: assert property (p_row_hit) else $error("row hit wrong");
	property p_col_hit;
		s_col |=> COL_HIT == ((($past(COL_ID) ^ $past(HUB_ID)) & 3'h6) == 3'h0);
	endproperty
	a_col_hit: assert property (p_col_hit) else $error("column hit wrong");
	property p_row_cha;
		s_row |=> ROW_CHA_HIT == (ROW_HIT && ($past(ROW_ID) & 3'h1) == 3'h0 && $past(CHA_ON));
	endproperty
	a_row_cha: assert property (p_row_cha) else $error("row channel A hit wrong");
	property p_col_chb;
		s_col |=> COL_CHB_HIT == (COL_HIT && ($past(COL_ID) & 3'h1) == 3'h1 && $past(CHB_ON));
	endproperty
	a_col_chb: assert property (p_col_chb) else $error("column channel B hit wrong");
	property p_idle;
		CE && !ROW_VALID |=> !ROW_HIT;
	endproperty
	a_idle: assert property (p_idle) else $error("row hit without packet");
	property p_cha_off;
		!CHA_ON |=> !ROW_CHA_HIT && !COL_CHA_HIT;
	endproperty
	a_cha_off: assert property (p_cha_off) else $error("channel A hit while off");
	property p_chb_off;
		!CHB_ON |=> !ROW_CHB_HIT && !COL_CHB_HIT;
	endproperty
	a_chb_off: assert property (p_chb_off) else $error("channel B hit while off");
	// reset is asynchronous, so this one must not be disabled by it
	property p_reset;
		disable iff (1'b0) !RST_N |-> {HUB_ID, EXP_DRIVE, CHA_ON, CHA_DRIVE, CHB_ON, CHB_DRIVE} == 26'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("configuration not cleared in reset");
	property p_cfg;
		$past(RST_N) && $changed({HUB_ID, EXP_DRIVE, CHA_ON, CHA_DRIVE, CHB_ON, CHB_DRIVE}) |-> SIO_SCK;
	endproperty
	a_cfg: assert property (p_cfg) else $error("configuration changed off a serial rise");
	property p_oe;
		$rose(SIO_OE) |-> !SIO_SCK;
	endproperty
	a_oe: assert property (p_oe) else $error("hub drive began outside a serial fall");
endmodule

bind hcr_top hcr_top_assertions chk (.*);

//--- verif/hcr_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// host side of the hub serial line
// ----------------------------------------
module hcr_host (
	// clock
	input wire clk,
	// hub side
	input wire hub_d,
	input wire hub_oe,
	// host side
	output reg sck,
	output wire line
);
	reg sd;
	reg drv;
	// released line shows the inverse of the last bit, never a stale copy
	assign line = hub_oe ? hub_d : (drv ? sd : ~sd);
	initial
	begin
		sck = 1'b0;
		sd = 1'b0;
		drv = 1'b1;
	end
	// half period of 8 cycles, twice the minimum the hub needs
	task half;
		repeat (8) @(posedge clk);
	endtask
	task frame(input [1:0] c, input [2:0] i, input [3:0] a, input [15:0] w, output [15:0] r);
		reg [25:0] f;
		integer k;
		begin
			f = {1'b1, c, i, a, w};
			r = 16'h0000;
			for (k = 0; k < ((c == 2'h2) ? 10 : 26); k = k + 1)
			begin
				if (k < 10 || c != 2'h1)
					sd <= f[25 - k];
				else
					drv <= 1'b0;
				half;
				sck <= 1'b1;
				if (k >= 10)
					r = {r[14:0], line};
				half;
				sck <= 1'b0;
			end
			sd <= 1'b0;
			drv <= 1'b1;
			repeat (16) @(posedge clk);
		end
	endtask
endmodule

//--- verif/test_hub_config_registers.sv
`timescale 1ns/100ps
// ----------------------------------------
// bench for the register bank
// ----------------------------------------
module test_hub_config_registers;
	reg clk, rst_n, rv, cv;
	reg [2:0] rid, cid, id;
	reg [15:0] rd, wd, m_exp, m_cha, m_chb, e;
	reg [3:0] a;
	integer n_mismatch, cmp_count, seed, k;
	wire sck, line, sout, soe, rh, rha, rhb, ch, cha, chb, aon, bon;
	wire [2:0] hub;
	wire [6:0] exd, adr, bdr;
	hcr_top dut (.SYS_CLK(clk), .RST_N(rst_n), .CE(1'b1), .SIO_SCK(sck), .SIO_IN(line), .SIO_OUT(sout),
		.SIO_OE(soe), .ROW_VALID(rv), .ROW_ID(rid), .COL_VALID(cv), .COL_ID(cid), .ROW_HIT(rh),
		.ROW_CHA_HIT(rha), .ROW_CHB_HIT(rhb), .COL_HIT(ch), .COL_CHA_HIT(cha), .COL_CHB_HIT(chb),
		.HUB_ID(hub), .EXP_DRIVE(exd), .CHA_ON(aon), .CHA_DRIVE(adr), .CHB_ON(bon), .CHB_DRIVE(bdr));
	hcr_host host (.clk(clk), .hub_d(sout), .hub_oe(soe), .sck(sck), .line(line));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task check(input [8*8-1:0] what, input [31:0] ex, input [31:0] seen);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== ex)
			begin
				$display("[FAIL] %0s expected %h seen %h", what, ex, seen);
				n_mismatch = n_mismatch + 1;
			end
		end
	endtask
	task finish_test;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
			if (n_mismatch == 0 && cmp_count > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// hub number compare under mask 110, channel bit under mask 001
	function [2:0] hits(input [2:0] p, input [2:0] h, input ea, input eb);
		reg hit;
		begin
			hit = ((p ^ h) & 3'h6) == 3'h0;
			hits = {hit, hit & ~p[0] & ea, hit & p[0] & eb};
		end
	endfunction
	task pkts(input integer n);
		integer j;
		for (j = 0; j < n; j = j + 1)
		begin
			@(posedge clk);
			rv <= 1'b1;
			cv <= 1'b1;
			rid <= $random(seed);
			cid <= $random(seed);
			@(posedge clk);
			rv <= 1'b0;
			cv <= 1'b0;
			#1;
			check("row hits", hits(rid, hub, m_exp[9], m_exp[10]), {rh, rha, rhb});
			check("col hits", hits(cid, hub, m_exp[9], m_exp[10]), {ch, cha, chb});
		end
	endtask
	initial
	begin
		#(4 * 60000);
		n_mismatch = n_mismatch + 1;
		finish_test;
	end
	initial
	begin
		seed = 32'h5E56;
		n_mismatch = 0;
		cmp_count = 0;
		// a real falling edge, once every reset process waits for it
		rst_n = 1'b1;
		{rv, cv, rid, cid} = 8'h00;
		{m_exp, m_cha, m_chb} = 48'h0;
		#1;
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		host.frame(2'h1, 3'h0, 4'h2, 16'h0000, rd);
		check("ident", 16'h04C0, rd);
		for (k = 4; k <= 10; k = k + 2)
		begin
			host.frame(2'h1, 3'h0, k, 16'h0000, rd);
			check("reg rst", 16'h0000, rd);
		end
		check("cfg rst", 26'h0, {hub, exd, aon, adr, bon, bdr});
		pkts(12);
		$display("test reset done");
		id = $random(seed);
		if (id == 3'h0)
			id = 3'h5;
		wd = $random(seed);
		host.frame(2'h3, 3'h0, 4'h0, {wd[15:3], id}, rd);
		host.frame(2'h1, id, 4'h2, 16'h0000, rd);
		check("new id", {13'h0098, id}, rd);
		host.frame(2'h0, id ^ 3'h2, 4'h4, 16'h067F, rd);
		check("foreign", 7'h00, exd);
		// foreign read: no hub drives, the released line reads as ones
		host.frame(2'h1, id ^ 3'h4, 4'h2, 16'h0000, rd);
		check("no drive", 16'hFFFF, rd);
		$display("test identity done");
		// enables go from zero to one once only, never back
		for (k = 0; k < 9; k = k + 1)
		begin
			a = 4'h4 + 4'h2 * (k % 3);
			wd = $random(seed);
			if (a == 4'h4)
				wd = (wd & 16'hF9FF) | ((k < 3) ? 16'h0200 : 16'h0600);
			host.frame(2'h0, id, a, wd, rd);
			if (a == 4'h4)
				m_exp = wd & 16'h067F;
			else if (a == 4'h6)
				m_cha = wd & 16'h007F;
			else
				m_chb = wd & 16'h007F;
			e = (a == 4'h4) ? m_exp : (a == 4'h6) ? m_cha : m_chb;
			host.frame(2'h1, id, a, 16'h0000, rd);
			check("readback", e, rd);
			check("drives", {m_exp[6:0], m_exp[9], m_cha[6:0], m_exp[10], m_chb[6:0]},
				{exd, aon, adr, bon, bdr});
			pkts(8);
		end
		$display("test registers done");
		// identity rewritten through its own offset
		wd = $random(seed);
		host.frame(2'h0, id, 4'h2, wd, rd);
		host.frame(2'h1, wd[2:0], 4'h2, 16'h0000, rd);
		check("id write", {13'h0098, wd[2:0]}, rd);
		// broadcast device reset returns every register to its default
		host.frame(2'h2, 3'h0, 4'h0, 16'h0000, rd);
		{m_exp, m_cha, m_chb} = 48'h0;
		check("devrst", 26'h0, {hub, exd, aon, adr, bon, bdr});
		pkts(4);
		$display("test device reset done");
		// reset in mid-run must clear without waiting for a clock edge
		host.frame(2'h0, 3'h0, 4'h4, 16'h067F, rd);
		check("reload", 9'h1FF, {exd, aon, bon});
		@(posedge clk);
		rst_n <= 1'b0;
		#1;
		check("rst mid", 26'h0, {hub, exd, aon, adr, bon, bdr});
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		{m_exp, m_cha, m_chb} = 48'h0;
		host.frame(2'h1, 3'h0, 4'h2, 16'h0000, rd);
		check("ident", 16'h04C0, rd);
		pkts(4);
		$display("test mid reset done");
		finish_test;
	end
endmodule
